// File: design/gpc_pkg.sv
// shared constants for the gpio pin control block
package gpc_pkg;
	// pin vector spans bit positions 0..9, seven of them are real pins
	localparam int GPC_PIN_W = 10;
	localparam logic [GPC_PIN_W-1:0] GPC_PIN_MASK = 10'h38f;
	// pins whose alternate function is an output
	localparam logic [GPC_PIN_W-1:0] GPC_ALT_OUT_MASK = 10'h381;
	// alternate function pin positions
	localparam int GPC_PIN_PORT2_RST = 0;
	localparam int GPC_PIN_IRQ = 2;
	localparam int GPC_PIN_EVENT = 7;
	localparam int GPC_PIN_PORT1_RST = 8;
	localparam int GPC_PIN_PORT3_RST = 9;
	// apb register byte offsets
	localparam logic [11:0] GPC_OFF_FUNC = 12'h000;
	localparam logic [11:0] GPC_OFF_DIR = 12'h004;
	localparam logic [11:0] GPC_OFF_DATA = 12'h008;
	// reset values: every pin a general input
	localparam logic [GPC_PIN_W-1:0] GPC_RST_FUNC = 10'h000;
	localparam logic [GPC_PIN_W-1:0] GPC_RST_DIR = 10'h000;
	localparam logic [GPC_PIN_W-1:0] GPC_RST_DATA = 10'h000;
	// sampling interval, a least time so it rounds up
	localparam int GPC_CLK_PERIOD_NS = 20;
	localparam int GPC_SAMPLE_NS = 128;
	localparam int GPC_SAMPLE_CYCLES = (GPC_SAMPLE_NS + GPC_CLK_PERIOD_NS - 1) / GPC_CLK_PERIOD_NS;
	localparam int GPC_CNT_W = 3;
	localparam logic [GPC_CNT_W-1:0] GPC_CNT_LAST = 3'(GPC_SAMPLE_CYCLES - 1);
endpackage

// File: design/gpc_pin_sync.sv
// two-stage synchroniser for a vector of asynchronous pins
module gpc_pin_sync
#(
	parameter int WIDTH = 10
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta;
	logic [WIDTH-1:0] next_meta;
	logic [WIDTH-1:0] next_sync_out;

	// first stage feeds only the second stage
	always_comb
	begin
		next_meta = async_in;
		next_sync_out = meta;
	end

	// reset to all ones: pins idle high like the active-low signals on them
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta <= {WIDTH{1'b1}};
			sync_out <= {WIDTH{1'b1}};
		end
		else
		begin
			meta <= next_meta;
			sync_out <= next_sync_out;
		end
	end

	// each pin passes exactly two flops, one edge per stage
	property p_two_stage;
		@(posedge pclk) disable iff (!presetn)
		$past(presetn) |-> (meta == $past(async_in)) && (sync_out == $past(meta));
	endproperty
	a_two_stage: assert property (p_two_stage)
		else $error("pin synchroniser stage skipped");
endmodule

// File: design/gpc_gpio_pin_control.sv
// gpio pin control: apb registers, pin muxing and input sampling
// Notes on behaviour
// - seven pins, each input, output or alternate.
// - control registers reachable by configuration accesses.
// - one bit per pin in each register.
// - func 0 selects input/output by direction; func 1 alternate.
// - pins 0, 8, 9 drive downstream port resets.
// - pin 2 expander interrupt in; pin 7 event out.
// - after reset every pin is general input.
// - sample inputs no faster than every 128 ns.
// - unused alternate signal held inactive internally.
// - general input level registered into data bit.
// - data read returns actual pin level always.
// - general output drives data register bit.
// - alternate function signal governs the pin.
//
// Register access over APB and the address map were chosen for this implementation.
module gpc_gpio_pin_control
#(
	parameter int PADDR_W = 12
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [PADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [gpc_pkg::GPC_PIN_W-1:0] pin_in,
	output logic [gpc_pkg::GPC_PIN_W-1:0] pin_out,
	output logic [gpc_pkg::GPC_PIN_W-1:0] pin_oe_n,
	input wire logic port2_reset_out_n,
	input wire logic port1_reset_out_n,
	input wire logic port3_reset_out_n,
	input wire logic general_event_out_n,
	output logic expander_irq_in_n
);
	import gpc_pkg::*;

	localparam logic [31-GPC_PIN_W:0] PAD = '0;

	logic [GPC_PIN_W-1:0] pin_function_select;
	logic [GPC_PIN_W-1:0] pin_direction_config;
	logic [GPC_PIN_W-1:0] pin_data_value;
	logic [GPC_PIN_W-1:0] level;
	logic [GPC_PIN_W-1:0] pin_sync;
	logic [GPC_PIN_W-1:0] alt_value;
	logic [GPC_CNT_W-1:0] count;
	logic sample_tick;
	logic access;
	logic [11:0] addr;
	logic [GPC_PIN_W-1:0] next_pin_function_select;
	logic [GPC_PIN_W-1:0] next_pin_direction_config;
	logic [GPC_PIN_W-1:0] next_pin_data_value;
	logic [GPC_PIN_W-1:0] next_level;
	logic [GPC_CNT_W-1:0] next_count;
	logic [31:0] next_prdata;
	logic next_pready;
	logic next_pslverr;
	logic [GPC_PIN_W-1:0] next_pin_out;
	logic [GPC_PIN_W-1:0] next_pin_oe_n;
	logic next_expander_irq_in_n;

	// pins are asynchronous, so nothing reads them before two flops
	gpc_pin_sync #(
		.WIDTH(GPC_PIN_W)
	) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(pin_in),
		.sync_out(pin_sync)
	);

	// bus decode helpers
	assign access = psel && penable;
	assign addr = 12'(paddr);
	assign sample_tick = (count == GPC_CNT_LAST);

	// apb slave: one wait state, then pready with registered read data
	always_comb
	begin
		next_pin_function_select = pin_function_select;
		next_pin_direction_config = pin_direction_config;
		next_pin_data_value = pin_data_value;
		next_prdata = prdata;
		next_pready = 1'b0;
		next_pslverr = 1'b0;
		if (access && !pready)
		begin
			next_pready = 1'b1;
			case (addr)
				GPC_OFF_FUNC: next_prdata = {PAD, pin_function_select};
				GPC_OFF_DIR: next_prdata = {PAD, pin_direction_config};
				GPC_OFF_DATA: next_prdata = {PAD, level};
				default:
				begin
					next_prdata = 32'h0000_0000;
					next_pslverr = 1'b1;
				end
			endcase
		end
		// writes land only at the edge that completes the transfer
		if (access && pready && pwrite)
		begin
			case (addr)
				GPC_OFF_FUNC: next_pin_function_select = pwdata[GPC_PIN_W-1:0] & GPC_PIN_MASK;
				GPC_OFF_DIR: next_pin_direction_config = pwdata[GPC_PIN_W-1:0] & GPC_PIN_MASK;
				GPC_OFF_DATA: next_pin_data_value = pwdata[GPC_PIN_W-1:0] & GPC_PIN_MASK;
				default: next_pin_data_value = pin_data_value;
			endcase
		end
	end

	// register file; reset leaves every pin a general input
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pin_function_select <= GPC_RST_FUNC;
			pin_direction_config <= GPC_RST_DIR;
			pin_data_value <= GPC_RST_DATA;
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pin_function_select <= next_pin_function_select;
			pin_direction_config <= next_pin_direction_config;
			pin_data_value <= next_pin_data_value;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	// sample timer: the level register moves once per interval only
	always_comb
	begin
		next_count = sample_tick ? '0 : count + 3'h1;
		next_level = level;
		if (sample_tick)
		begin
			next_level = pin_sync & GPC_PIN_MASK;
		end
	end

	// sampled level reflects every pin, whatever its mode
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			count <= '0;
			level <= GPC_RST_DATA;
		end
		else
		begin
			count <= next_count;
			level <= next_level;
		end
	end

	// alternate output sources gathered by pin position
	always_comb
	begin
		alt_value = {GPC_PIN_W{1'b1}};
		alt_value[GPC_PIN_PORT2_RST] = port2_reset_out_n;
		alt_value[GPC_PIN_PORT1_RST] = port1_reset_out_n;
		alt_value[GPC_PIN_PORT3_RST] = port3_reset_out_n;
		alt_value[GPC_PIN_EVENT] = general_event_out_n;
	end

	// pin mux; pins with no output alternate release the pin under func 1
	always_comb
	begin
		next_pin_out = {GPC_PIN_W{1'b0}};
		next_pin_oe_n = {GPC_PIN_W{1'b1}};
		for (int i = 0; i < GPC_PIN_W; i++)
		begin
			if (GPC_PIN_MASK[i])
			begin
				if (pin_function_select[i] && GPC_ALT_OUT_MASK[i])
				begin
					next_pin_out[i] = alt_value[i];
					next_pin_oe_n[i] = 1'b0;
				end
				else if (!pin_function_select[i] && pin_direction_config[i])
				begin
					next_pin_out[i] = pin_data_value[i];
					next_pin_oe_n[i] = 1'b0;
				end
			end
		end
		// expander interrupt held inactive unless its pin is alternate
		next_expander_irq_in_n = 1'b1;
		if (pin_function_select[GPC_PIN_IRQ])
		begin
			next_expander_irq_in_n = pin_sync[GPC_PIN_IRQ];
		end
	end

	// outputs registered so the pads never see decode glitches
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pin_out <= {GPC_PIN_W{1'b0}};
			pin_oe_n <= {GPC_PIN_W{1'b1}};
			expander_irq_in_n <= 1'b1;
		end
		else
		begin
			pin_out <= next_pin_out;
			pin_oe_n <= next_pin_oe_n;
			expander_irq_in_n <= next_expander_irq_in_n;
		end
	end

	// helper for checks: set once software has written anything
	logic written_any;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			written_any <= 1'b0;
		end
		else if (access && pready && pwrite)
		begin
			written_any <= 1'b1;
		end
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_first_access;
		access && !pready;
	endsequence

	sequence s_answer;
		pready ##1 !pready;
	endsequence

	property p_apb_answer;
		s_first_access |=> s_answer;
	endproperty
	a_apb_answer: assert property (p_apb_answer)
		else $error("apb answer not after one wait state");

	property p_reset_inputs;
		!written_any |-> (pin_oe_n == {GPC_PIN_W{1'b1}}) && expander_irq_in_n;
	endproperty
	a_reset_inputs: assert property (p_reset_inputs)
		else $error("pin driven before any configuration write");

	property p_input_mode;
		(!pin_function_select[1] && !pin_direction_config[1]) |=> pin_oe_n[1];
	endproperty
	a_input_mode: assert property (p_input_mode)
		else $error("general input pin is being driven");

	property p_output_mode;
		(!pin_function_select[3] && pin_direction_config[3])
			|=> !pin_oe_n[3] && (pin_out[3] == $past(pin_data_value[3]));
	endproperty
	a_output_mode: assert property (p_output_mode)
		else $error("general output does not follow data bit");

	property p_port_reset_alt;
		pin_function_select[GPC_PIN_PORT1_RST]
			|=> !pin_oe_n[GPC_PIN_PORT1_RST]
			&& (pin_out[GPC_PIN_PORT1_RST] == $past(port1_reset_out_n));
	endproperty
	a_port_reset_alt: assert property (p_port_reset_alt)
		else $error("port reset alternate not routed to pin");

	property p_event_alt;
		pin_function_select[GPC_PIN_EVENT]
			|=> pin_out[GPC_PIN_EVENT] == $past(general_event_out_n);
	endproperty
	a_event_alt: assert property (p_event_alt)
		else $error("event alternate not routed to pin");

	property p_irq_held;
		!pin_function_select[GPC_PIN_IRQ] |=> expander_irq_in_n
			&& (pin_oe_n[GPC_PIN_IRQ] == !$past(pin_direction_config[GPC_PIN_IRQ]));
	endproperty
	a_irq_held: assert property (p_irq_held)
		else $error("expander interrupt active while pin is gpio");

	property p_sample_spacing;
		sample_tick |=> !sample_tick [*6] ##1 sample_tick;
	endproperty
	a_sample_spacing: assert property (p_sample_spacing)
		else $error("input sampling interval wrong");

	property p_level_capture;
		sample_tick |=> level == ($past(pin_sync) & GPC_PIN_MASK);
	endproperty
	a_level_capture: assert property (p_level_capture)
		else $error("sampled level not captured");

	property p_level_hold;
		!sample_tick |=> $stable(level);
	endproperty
	a_level_hold: assert property (p_level_hold)
		else $error("level changed between samples");

	property p_data_read;
		(s_first_access ##0 (addr == GPC_OFF_DATA)) |=> prdata == {PAD, $past(level)};
	endproperty
	a_data_read: assert property (p_data_read)
		else $error("data read does not return pin level");

	property p_unimpl_zero;
		pready |-> (prdata[GPC_PIN_W-1:0] & ~GPC_PIN_MASK) == '0
			&& pin_oe_n[4] && pin_oe_n[5] && pin_oe_n[6];
	endproperty
	a_unimpl_zero: assert property (p_unimpl_zero)
		else $error("unimplemented pin bit visible");

	property p_alt_irq_pin;
		pin_function_select[GPC_PIN_IRQ] |=> pin_oe_n[GPC_PIN_IRQ]
			&& expander_irq_in_n == $past(pin_sync[GPC_PIN_IRQ]);
	endproperty
	a_alt_irq_pin: assert property (p_alt_irq_pin)
		else $error("expander interrupt input path wrong");

	property p_pin_count;
		(pin_function_select & ~GPC_PIN_MASK) == '0 && $countones(GPC_PIN_MASK) == 7;
	endproperty
	a_pin_count: assert property (p_pin_count)
		else $error("function select outside the seven pins");

	property p_per_pin_bits;
		(access && pready && pwrite && addr == GPC_OFF_DIR)
			|=> pin_direction_config == ($past(pwdata[GPC_PIN_W-1:0]) & GPC_PIN_MASK);
	endproperty
	a_per_pin_bits: assert property (p_per_pin_bits)
		else $error("direction write not stored per pin");
endmodule

// File: bench/gpc_board_model.sv
// board loads on the pins: resolves each wire and syncs outputs into the board clock
module gpc_board_model
import gpc_pkg::*;
(
	input wire logic pclk,
	input wire logic [GPC_PIN_W-1:0] pin_out,
	input wire logic [GPC_PIN_W-1:0] pin_oe_n,
	input wire logic [GPC_PIN_W-1:0] ext_drive,
	output logic [GPC_PIN_W-1:0] pin_level,
	output logic [GPC_PIN_W-1:0] board_seen
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [GPC_PIN_W-1:0] meta;
	// the board lets go of a pin whenever the device drives it, so no contention
	assign pin_level = (pin_out & ~pin_oe_n) | (ext_drive & pin_oe_n);
	// outputs are asynchronous to the board, two flops before use
	always @(posedge pclk)
	begin
		meta <= pin_level;
		board_seen <= meta;
	end
endmodule

// File: bench/gpio_pin_control_tb.sv
// self-checking bench for the gpio pin control block
module gpio_pin_control_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import gpc_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [9:0] pin_in;
	logic [9:0] pin_out;
	logic [9:0] pin_oe_n;
	logic [9:0] ext = 10'h000;
	logic [9:0] seen;
	logic src2 = 1'b0;
	logic src1 = 1'b1;
	logic src3 = 1'b0;
	logic srcev = 1'b1;
	logic irq_n;
	logic [31:0] rd;
	logic er;
	int err_count = 0;
	int checks = 0;
	int cycles = 0;

	// 20 ns period
	always #10 pclk = ~pclk;

	gpc_gpio_pin_control #(.PADDR_W(12)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe_n(pin_oe_n), .port2_reset_out_n(src2), .port1_reset_out_n(src1),
		.port3_reset_out_n(src3), .general_event_out_n(srcev), .expander_irq_in_n(irq_n));

	gpc_board_model board_u (.pclk(pclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
		.ext_drive(ext), .pin_level(pin_in), .board_seen(seen));

	task test_done();
		if (err_count == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask

	// one apb transfer; holds everything until pready is sampled high
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task t_reset();
		chk("oe_n", 32'h3ff, pin_oe_n);
		chk("irq_n", 32'h1, irq_n);
		apb(1'b0, GPC_OFF_FUNC, 32'h0);
		chk("func", 32'h0, rd);
		chk("mapped err", 32'h0, er);
		apb(1'b0, GPC_OFF_DIR, 32'h0);
		chk("dir", 32'h0, rd);
	endtask

	task t_map();
		apb(1'b0, 12'h00c, 32'h0);
		chk("unmapped err", 32'h1, er);
		apb(1'b1, GPC_OFF_DIR, 32'hffff_ffff);
		apb(1'b0, GPC_OFF_DIR, 32'h0);
		chk("dir bits", 32'h38f, rd);
		@(posedge pclk);
		chk("oe_n all out", 32'h070, pin_oe_n);
		apb(1'b1, GPC_OFF_DIR, 32'h0);
	endtask

	task t_input();
		ext <= 10'h275;
		repeat (12) @(posedge pclk);
		apb(1'b0, GPC_OFF_DATA, 32'h0);
		chk("input level", 32'h205, rd);
	endtask

	task t_output();
		ext <= 10'h3ff;
		apb(1'b1, GPC_OFF_DATA, 32'h082);
		apb(1'b1, GPC_OFF_DIR, 32'h08b);
		repeat (2) @(posedge pclk);
		chk("out oe_n", 32'h374, pin_oe_n);
		chk("out value", 32'h082, pin_out & 10'h08b);
		repeat (12) @(posedge pclk);
		chk("board seen", 32'h082, seen & 10'h08b);
		apb(1'b0, GPC_OFF_DATA, 32'h0);
		chk("out level", 32'h386, rd);
	endtask

	task t_alt();
		ext <= 10'h000;
		apb(1'b1, GPC_OFF_DIR, 32'h002);
		apb(1'b1, GPC_OFF_FUNC, 32'h38f);
		repeat (4) @(posedge pclk);
		chk("alt oe_n", 32'h07e, pin_oe_n);
		chk("alt out", 32'h180, pin_out & 10'h381);
		chk("irq low", 32'h0, irq_n);
		src2 <= 1'b1;
		src1 <= 1'b0;
		repeat (12) @(posedge pclk);
		chk("alt swap", 32'h081, pin_out & 10'h381);
		apb(1'b0, GPC_OFF_DATA, 32'h0);
		chk("alt level", 32'h081, rd);
		apb(1'b1, GPC_OFF_FUNC, 32'h0);
		repeat (4) @(posedge pclk);
		chk("irq held", 32'h1, irq_n);
		chk("gp oe_n", 32'h3fd, pin_oe_n);
	endtask

	// hang guard, the sequence needs about 120 cycles
	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			err_count++;
			test_done();
		end
	end

	initial
	begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_map();
		t_input();
		t_output();
		t_alt();
		test_done();
	end
endmodule
